// ==== rtcsp_map.vh ====
// register port constants for the rtc two-wire target port
`ifndef RTCSP_MAP_VH
`define RTCSP_MAP_VH
// 7-bit target address; value is arbitrary
`define RTCSP_TARGET_ADDR 7'h32
`define RTCSP_ADDR_W 8
`define RTCSP_DATA_W 8
`define RTCSP_PTR_RESET 8'h00
// longest transfer time, in milliseconds, and its count at 100 mhz
`define RTCSP_XFER_MAX_MS 950
`define RTCSP_CLK_MHZ 100
`define RTCSP_XFER_MAX_CYC (`RTCSP_XFER_MAX_MS * 1000 * `RTCSP_CLK_MHZ)
`endif

// ==== rtcsp_port.v ====
// rtc two-wire target port: framing, address match, pointer, data path
//
// What this block does
// - rising data with clock high ends transfer
// - repeated start restarts address reception
// - answer only own fixed target address
// - direction bit picks receive or transmit
// - lines only pulled low or released
// - register address byte loads pointer, acknowledged
// - written bytes stored, pointer advances by one
// - after read address, device sends pointer data
// - host ack continues read, nack ends
// - pointer kept between transfers for bare reads
// - acknowledge received bytes, advance after sends
// - bytes of eight bits, transfer within 0.95 s; a longer transfer only raises xfer_overtime and goes on
// - calendar frozen while transfer active
`timescale 1ns/100ps
`include "rtcsp_map.vh"

module rtcsp_port #(
	parameter [6:0] TARGET_ADDR = `RTCSP_TARGET_ADDR,
	parameter [31:0] XFER_MAX_CYC = `RTCSP_XFER_MAX_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// two-wire bus, open drain
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe_n,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	// register side
	output reg [`RTCSP_ADDR_W-1:0] reg_addr,
	output reg [`RTCSP_DATA_W-1:0] reg_wdata,
	output reg reg_wr,
	output reg reg_rd,
	input wire [`RTCSP_DATA_W-1:0] reg_rdata,
	output reg xfer_active,
	output reg xfer_overtime
);

// ----------------------------------------------------------------
// reset release and input synchronisers
// ----------------------------------------------------------------
reg [1:0] rst_sync;
wire rst_int_n;
wire scl_s;
wire sda_s;
wire scl_d;
wire sda_d;

always @(posedge ref_clk or negedge rst_n) begin
	if (!rst_n)
		rst_sync <= 2'h0;
	else
		rst_sync <= {rst_sync[0], 1'b1};
end
assign rst_int_n = rst_sync[1];

// pin 0 is the clock line, pin 1 the data line; both reset to the idle
// high level so that no false edge follows reset
localparam PINS = 2;
wire [PINS-1:0] pin_raw;
wire [PINS-1:0] pin_now;
wire [PINS-1:0] pin_prev;
assign pin_raw = {sda_in, scl_in};

genvar g;
generate
	for (g = 0; g < PINS; g = g + 1) begin : pin_sync
		reg [1:0] meta;
		reg prev;
		always @(posedge ref_clk or negedge rst_int_n) begin
			if (!rst_int_n) begin
				meta <= 2'h3;
				prev <= 1'b1;
			end else begin
				meta <= {meta[0], pin_raw[g]};
				prev <= meta[1];
			end
		end
		assign pin_now[g] = meta[1];
		assign pin_prev[g] = prev;
	end
endgenerate

assign scl_s = pin_now[0];
assign sda_s = pin_now[1];
assign scl_d = pin_prev[0];
assign sda_d = pin_prev[1];
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
// clock held high on both samples keeps a data edge from being misread
wire start_det = scl_s & scl_d & sda_d & ~sda_s;
wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

// ----------------------------------------------------------------
// decoding shared by the byte engine
// ----------------------------------------------------------------
// a one is sent by letting go of the line; the pull-up does the rest
function oe_n_of;
	input bit_val;
	begin
		oe_n_of = bit_val ? 1'b1 : 1'b0;
	end
endfunction

// the address byte carries the target address above the direction bit
function addr_hit;
	input [7:0] addr_byte;
	begin
		addr_hit = (addr_byte[7:1] == TARGET_ADDR);
	end
endfunction

// ----------------------------------------------------------------
// byte engine
// ----------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_AACK = 3'h2;
localparam ST_RXB = 3'h3;
localparam ST_RACK = 3'h4;
localparam ST_TXB = 3'h5;
localparam ST_TACK = 3'h6;

reg [2:0] state;
reg [2:0] bit_cnt;
reg [7:0] shift;
reg rd_mode;
reg ptr_phase;
reg ack_drive;
reg [31:0] xfer_cnt;
reg last_was_data;

always @(posedge ref_clk or negedge rst_int_n) begin
	if (!rst_int_n) begin
		state <= ST_IDLE;
		bit_cnt <= 3'h0;
		shift <= 8'h00;
		rd_mode <= 1'b0;
		ptr_phase <= 1'b0;
		ack_drive <= 1'b0;
		reg_addr <= `RTCSP_PTR_RESET;
		reg_wdata <= 8'h00;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		sda_out <= 1'b0;
		sda_oe_n <= 1'b1;
		scl_out <= 1'b0;
		scl_oe_n <= 1'b1;
		xfer_active <= 1'b0;
	end else begin
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		// clock line is never pulled: no stretching
		scl_oe_n <= 1'b1;
		// a start or stop mid-acknowledge must not leave a stale ack
		if (stop_det) begin
			state <= ST_IDLE;
			sda_oe_n <= 1'b1;
			ack_drive <= 1'b0;
			// calendar side releases its frozen copy here
			xfer_active <= 1'b0;
		end else if (start_det) begin
			state <= ST_ADDR;
			bit_cnt <= 3'h0;
			sda_oe_n <= 1'b1;
			ack_drive <= 1'b0;
			xfer_active <= 1'b1;
		end else begin
			case (state)
			ST_IDLE: begin
				// also the parked state after a mismatch
				sda_oe_n <= 1'b1;
			end
			ST_ADDR, ST_RXB: begin
				if (scl_rise) begin
					shift <= {shift[6:0], sda_s};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7)
						state <= (state == ST_ADDR) ? ST_AACK : ST_RACK;
				end
			end
			ST_AACK: begin
				if (scl_fall) begin
					if (addr_hit(shift) && ack_drive == 1'b0) begin
						sda_oe_n <= 1'b0;
						ack_drive <= 1'b1;
						rd_mode <= shift[0];
						ptr_phase <= ~shift[0];
						if (shift[0])
							reg_rd <= 1'b1;
					end else if (ack_drive) begin
						ack_drive <= 1'b0;
						bit_cnt <= 3'h0;
						if (rd_mode) begin
							state <= ST_TXB;
							sda_oe_n <= oe_n_of(reg_rdata[7]);
							shift <= {reg_rdata[6:0], 1'b0};
							bit_cnt <= 3'h1;
						end else begin
							state <= ST_RXB;
							sda_oe_n <= 1'b1;
						end
					end else begin
						state <= ST_IDLE;
					end
				end
			end
			ST_RACK: begin
				if (scl_fall) begin
					if (!ack_drive) begin
						sda_oe_n <= 1'b0;
						ack_drive <= 1'b1;
						if (ptr_phase) begin
							reg_addr <= shift;
							ptr_phase <= 1'b0;
						end else begin
							reg_wdata <= shift;
							reg_wr <= 1'b1;
						end
					end else begin
						ack_drive <= 1'b0;
						sda_oe_n <= 1'b1;
						bit_cnt <= 3'h0;
						state <= ST_RXB;
						if (reg_wr == 1'b0 && xfer_active && !ptr_phase
							&& last_was_data)
							reg_addr <= reg_addr + 8'h01;
					end
				end
			end
			ST_TXB: begin
				if (scl_fall) begin
					if (bit_cnt == 3'h0) begin
						sda_oe_n <= 1'b1;
						state <= ST_TACK;
						reg_addr <= reg_addr + 8'h01;
					end else begin
						sda_oe_n <= oe_n_of(shift[7]);
						shift <= {shift[6:0], 1'b0};
						bit_cnt <= bit_cnt + 3'h1;
					end
				end
			end
			ST_TACK: begin
				if (scl_rise) begin
					if (sda_s) begin
						state <= ST_IDLE;
					end else begin
						reg_rd <= 1'b1;
						ack_drive <= 1'b1;
					end
				end else if (scl_fall && ack_drive) begin
					ack_drive <= 1'b0;
					state <= ST_TXB;
					sda_oe_n <= oe_n_of(reg_rdata[7]);
					shift <= {reg_rdata[6:0], 1'b0};
					bit_cnt <= 3'h1;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
end

// ----------------------------------------------------------------
// transfer timer
// ----------------------------------------------------------------
// overtime only flags the host's slip; the transfer itself goes on
always @(posedge ref_clk or negedge rst_int_n) begin
	if (!rst_int_n) begin
		xfer_cnt <= 32'h0;
		xfer_overtime <= 1'b0;
	end else if (start_det && !xfer_active) begin
		xfer_cnt <= 32'h0;
		xfer_overtime <= 1'b0;
	end else if (xfer_active) begin
		if (xfer_cnt < XFER_MAX_CYC)
			xfer_cnt <= xfer_cnt + 32'h1;
		if (xfer_cnt == XFER_MAX_CYC - 32'h1)
			xfer_overtime <= 1'b1;
	end
end

// ----------------------------------------------------------------
// write-pointer advance tracking
// ----------------------------------------------------------------
// advance after a stored byte, never after the pointer byte itself
always @(posedge ref_clk or negedge rst_int_n) begin
	if (!rst_int_n)
		last_was_data <= 1'b0;
	else if (reg_wr)
		last_was_data <= 1'b1;
	else if (state == ST_RXB)
		last_was_data <= 1'b0;
end

endmodule

// ==== rtcsp_port_properties.sv ====
// assertions on the ports of the rtc two-wire target port
`timescale 1ns/100ps
module rtcsp_props (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// bus
	input wire scl_in,
	input wire sda_in,
	input wire scl_oe_n,
	input wire sda_out,
	input wire sda_oe_n,
	// register side
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire xfer_active
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// pointer at the last access, to judge the step after it
	reg [7:0] last_ptr;
	always @(posedge ref_clk)
		if (reg_wr | reg_rd)
			last_ptr <= reg_addr;
	scl_released_a: assert property (scl_oe_n)
		else $error("clock line pulled");
	sda_low_only_a: assert property (!sda_oe_n |-> !sda_out)
		else $error("data driven high");
	idle_release_a: assert property (!xfer_active |-> sda_oe_n)
		else $error("data pulled while idle");
	start_active_a: assert property ($fell(sda_in) && scl_in |-> ##[1:8] xfer_active)
		else $error("start missed");
	stop_idle_a: assert property ($rose(sda_in) && scl_in |-> ##[1:8] !xfer_active)
		else $error("stop missed");
	wr_single_a: assert property (reg_wr |=> !reg_wr)
		else $error("write pulse too long");
	wr_step_a: assert property (reg_wr |=> ##[0:40] reg_addr == last_ptr + 8'h01)
		else $error("no step after write");
	rd_step_a: assert property (reg_rd |=> ##[0:200] reg_addr == last_ptr + 8'h01)
		else $error("no step after read");
	ack_in_low_a: assert property ($fell(sda_oe_n) |-> !scl_in)
		else $error("data pulled with clock high");
endmodule
bind rtcsp_port rtcsp_props chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.scl_in(scl_in), .sda_in(sda_in), .scl_oe_n(scl_oe_n),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .xfer_active(xfer_active));

// ==== rtcsp_host.sv ====
// bus controller model driving the two-wire bus, 160 ns per bit
`timescale 1ns/100ps
module rtcsp_host (
	input wire ref_clk,
	input wire sda,
	output reg scl,
	output reg sda_h
);
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	task q;
		begin
			repeat (4) @(posedge ref_clk);
			#1;
		end
	endtask
	// also serves as repeated start when the clock is low
	task start;
		begin
			sda_h = 1'b1; q; scl = 1'b1; q; sda_h = 1'b0; q; scl = 1'b0; q;
		end
	endtask
	task stop;
		begin
			sda_h = 1'b0; q; scl = 1'b1; q; sda_h = 1'b1; q;
		end
	endtask
	// a one only releases the line; the pull-up makes it high
	task bitx(input b, output r);
		begin
			sda_h = b; q; scl = 1'b1; q; r = sda; q; scl = 1'b0; q;
		end
	endtask
	// eight bits msb first, then the acknowledge bit (1 = nack)
	task byte_io(input [7:0] d, input a, output [7:0] r, output ra);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1)
				bitx(d[i], r[i]);
			bitx(a, ra);
		end
	endtask
endmodule

// ==== tb_top.sv ====
// self-checking testbench for the rtc two-wire target port
`timescale 1ns/100ps
`include "rtcsp_map.vh"
module tb_top;
	reg ref_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] reg_rdata = 8'h00;
	reg [7:0] mem [0:255];
	reg [7:0] ex [0:3];
	reg [15:0] wq [$];
	reg [7:0] d;
	reg [7:0] r;
	reg k;
	integer seed = 32'h480e;
	integer n_errors = 0;
	integer check_count = 0;
	integer i;
	wire scl_h, sda_h, scl_out, scl_oe_n, sda_out, sda_oe_n;
	wire reg_wr, reg_rd, xfer_active, xfer_overtime;
	wire [7:0] reg_addr, reg_wdata;
	wire scl = scl_h & (scl_oe_n | scl_out);
	wire sda = sda_h & (sda_oe_n | sda_out);
	wire [7:0] aw = {`RTCSP_TARGET_ADDR, 1'b0};
	wire [7:0] ar = {`RTCSP_TARGET_ADDR, 1'b1};
	always #5 ref_clk = ~ref_clk;
	rtcsp_port #(.XFER_MAX_CYC(2000)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .xfer_active(xfer_active),
		.xfer_overtime(xfer_overtime));
	rtcsp_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl_h), .sda_h(sda_h));
	task automatic chk(input [47:0] nm, input [15:0] e, input [15:0] s);
		begin
			check_count = check_count + 1;
			if (e !== s) begin
				n_errors = n_errors + 1;
				$display("ERROR %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask
	// one byte on the bus; compares bus data and the acknowledge bit
	task xb(input [7:0] dv, input ak, input [7:0] ed, input ea, input [47:0] nm);
		begin
			host.byte_io(dv, ak, r, k);
			chk(nm, {ed, 7'h00, ea}, {r, 7'h00, k});
		end
	endtask
	// register file beside the port; each write takes the oldest note
	always @(posedge ref_clk) begin
		if (reg_rd)
			reg_rdata <= mem[reg_addr];
		if (reg_wr) begin
			mem[reg_addr] <= reg_wdata;
			chk("write", wq.size() ? wq.pop_front() : 16'hxxxx, {reg_addr, reg_wdata});
		end
	end
	task print_verdict;
		begin
			$display("checks %0d errors %0d", check_count, n_errors);
			if (n_errors == 0 && check_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		#200000;
		n_errors = n_errors + 1;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (6) @(posedge ref_clk);
		host.start;
		xb(aw, 1, aw, 0, "addr");
		xb(8'h20, 1, 8'h20, 0, "ptr");
		for (i = 0; i < 4; i = i + 1) begin
			d = $random(seed);
			ex[i] = d;
			wq.push_back({8'h20 + i[7:0], d});
			xb(d, 1, d, 0, "wdata");
		end
		chk("ovt", 16'h0000, {15'h0000, xfer_overtime});
		chk("act", 16'h0001, {15'h0000, xfer_active});
		host.start;
		xb(8'h20 & 8'h00 | aw, 1, aw, 0, "addr");
		xb(8'h20, 1, 8'h20, 0, "ptr");
		host.start;
		xb(ar, 1, ar, 0, "addr_r");
		for (i = 0; i < 3; i = i + 1)
			xb(8'hff, i == 2, ex[i], i == 2, "rdata");
		host.stop;
		host.start;
		xb(ar, 1, ar, 0, "addr_r");
		xb(8'hff, 1, ex[3], 1, "rdata");
		host.stop;
		host.start;
		xb(aw ^ 8'h02, 1, aw ^ 8'h02, 1, "nack");
		xb(8'h20, 1, 8'h20, 1, "ignore");
		host.stop;
		host.start;
		xb(aw, 1, aw, 0, "addr");
		repeat (2100) @(posedge ref_clk);
		chk("ovt", 16'h0001, {15'h0000, xfer_overtime});
		host.stop;
		chk("act", 16'h0000, {15'h0000, xfer_active});
		chk("sclo", 16'h0001, {14'h0000, scl_out, scl_oe_n});
		chk("wq", 16'h0000, {15'h0000, wq.size() != 0});
		print_verdict;
	end
endmodule
